// file: core/bmd_map.svh
// Address map, field positions, reset values and vectors of the banked memory decoder.
`ifndef BMD_MAP_SVH
`define BMD_MAP_SVH

`define BMD_OFF_INDIRECT   7'h00
`define BMD_OFF_PC_LOW     7'h02
`define BMD_OFF_STATUS     7'h03
`define BMD_OFF_POINTER    7'h04
`define BMD_OFF_PC_LATCH   7'h0a
`define BMD_OFF_INT_CTRL   7'h0b
`define BMD_OFF_GPR_LO     7'h20
`define BMD_OFF_SHARED_LO  7'h70

`define BMD_BANK3          2'h3
`define BMD_BIAS_BANK0     8'he0
`define BMD_BIAS_BANK1     8'h40
`define BMD_BIAS_BANK2     8'h90

`define BMD_ST_IRP         7
`define BMD_ST_BANK_HI     6
`define BMD_ST_BANK_LO     5
`define BMD_ST_TIMEOUT     4
`define BMD_ST_POWERDOWN   3
`define BMD_ST_WR_MASK     8'he7

`define BMD_STATUS_RESET   8'h00
`define BMD_LATCH_RESET    5'h00
`define BMD_INTCTRL_RESET  8'h00
`define BMD_POINTER_RESET  8'h00

`define BMD_VEC_RESET      13'h0000
`define BMD_VEC_IRQ        13'h0004
`define BMD_PMASK_SMALL    13'h07ff
`define BMD_PMASK_LARGE    13'h0fff

`endif

// file: core/bmd_pkg.sv
// Types shared by the banked memory decoder, its checks and its core model.
package bmd_pkg;

   typedef struct packed {
      logic        we;
      logic [6:0]  offset;
      logic [7:0]  wdata;
   } bmd_data_cmd_t;

   typedef struct packed {
      logic        irq_take;
      logic        jump;
      logic        ret;
      logic        advance;
      logic [12:0] target;
   } bmd_pc_cmd_t;

   typedef struct packed {
      logic        we;
      logic [12:0] addr;
      logic [13:0] word;
   } bmd_prog_load_t;

   typedef enum logic [2:0] {
      BMD_RG_NONE = 3'h1,
      BMD_RG_RAM  = 3'h2,
      BMD_RG_REG  = 3'h4
   } bmd_region_t;

endpackage

// file: core/bmd_ram.sv
// Single-port-write, registered-read memory used for program store and data RAM.
`timescale 1ns/1ps
module bmd_ram #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   input  wire logic              wr_en_in,
   input  wire logic [ADDR_W-1:0] wr_addr_in,
   input  wire logic [DATA_W-1:0] wr_data_in,
   input  wire logic [ADDR_W-1:0] rd_addr_in,
   output logic      [DATA_W-1:0] rd_data_out
);
   logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         store[wr_addr_in] <= wr_data_in;
      end
   end

   // Read data is a register so the consumer sees a stable word for a full cycle.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= store[rd_addr_in];
      end
   end
endmodule

// file: core/bmd_decode.sv
// Program counter, program store and banked data memory decoder.
`timescale 1ns/1ps
`include "bmd_map.svh"
module bmd_decode #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   input  wire logic                   clk_in,
   input  wire logic                   reset_n_in,
   input  wire bmd_pkg::bmd_pc_cmd_t    pc_cmd_in,
   input  wire bmd_pkg::bmd_prog_load_t prog_load_in,
   output logic      [12:0]            pc_out,
   output logic      [13:0]            prog_word_out,
   input  wire logic                   data_req_in,
   input  wire bmd_pkg::bmd_data_cmd_t  data_cmd_in,
   output logic                        data_ack_out,
   output logic      [7:0]             data_rdata_out,
   input  wire logic                   flag_we_in,
   input  wire logic [2:0]             flag_in,
   input  wire logic                   timeout_flag_in,
   input  wire logic                   powerdown_flag_in,
   output logic      [7:0]             status_out,
   output logic      [7:0]             int_ctrl_out
);
   logic [12:0]         pc;
   logic [12:0]         next_pc;
   logic [7:0]          status_store;
   logic [4:0]          pc_latch;
   logic [7:0]          int_ctrl;
   logic [7:0]          pointer;
   logic [7:0]          reg_rdata;
   logic                ack;
   bmd_pkg::bmd_region_t region;
   bmd_pkg::bmd_region_t region_q;

   // One fetch and one data access complete in every cycle; neither port stalls the other,
   // which is why no arbitration appears below.
   // Program side. Fetch runs on its own port, independent of data accesses.
   // The store is always built for the larger size; the mask alone decides which words a
   // smaller part reaches, so both variants share one memory layout.
   wire [12:0] pstore_mask = LARGE_VARIANT ? `BMD_PMASK_LARGE : `BMD_PMASK_SMALL;
   wire [12:0] fetch_addr  = pc & pstore_mask;
   wire [12:0] load_addr   = prog_load_in.addr & pstore_mask;
   wire [12:0] jump_addr   = {pc_latch[4:3], pc_cmd_in.target[10:0]};

   // Data side decode. Offset zero swaps the direct address for the pointer, and every later
   // decode works on the effective address, so an indirect access to a core register or a
   // RAM byte lands where the direct access would.
   wire        acc         = data_req_in;
   wire        wr          = acc & data_cmd_in.we;
   wire [1:0]  bank_sel    = {status_store[`BMD_ST_BANK_HI],
                              status_store[`BMD_ST_BANK_LO]};
   wire        via_pointer = data_cmd_in.offset == `BMD_OFF_INDIRECT;
   wire [8:0]  direct_addr = {bank_sel, data_cmd_in.offset};
   // Status bit 7 is the upper bit of an indirect address, the partner of the pointer.
   wire [8:0]  ind_addr    = {status_store[`BMD_ST_IRP], pointer};
   wire [8:0]  eff_addr    = via_pointer ? ind_addr : direct_addr;
   wire [1:0]  eff_bank    = eff_addr[8:7];
   wire [6:0]  eff_off     = eff_addr[6:0];
   wire        in_shared   = eff_off >= `BMD_OFF_SHARED_LO;
   wire        in_gpr      = eff_off >= `BMD_OFF_GPR_LO;
   wire        ram_hit     = in_gpr & (in_shared | (eff_bank != `BMD_BANK3));
   // The 256-byte RAM packs bank 0 at indices 00h-5Fh, bank 1 at 60h-AFh and bank 2 at
   // B0h-FFh. Shared offsets always take the bank 0 bias, which is what lets banks 1 to 3
   // reach the same top sixteen bytes.
   wire [7:0]  off8        = {1'b0, eff_off};
   wire [7:0]  bias        = in_shared             ? `BMD_BIAS_BANK0 :
                             (eff_bank == 2'h0)    ? `BMD_BIAS_BANK0 :
                             (eff_bank == 2'h1)    ? `BMD_BIAS_BANK1 :
                                                     `BMD_BIAS_BANK2;
   wire [7:0]  ram_index   = 8'(off8 + bias);

   // Core registers answer at the same offset whatever the bank.
   wire        hit_pc_low  = eff_off == `BMD_OFF_PC_LOW;
   wire        hit_status  = eff_off == `BMD_OFF_STATUS;
   wire        hit_pointer = eff_off == `BMD_OFF_POINTER;
   wire        hit_latch   = eff_off == `BMD_OFF_PC_LATCH;
   wire        hit_intctl  = eff_off == `BMD_OFF_INT_CTRL;
   // The upper counter bits have no read path of their own; software sees only the latch.
   wire        reg_hit     = hit_pc_low | hit_status | hit_pointer | hit_latch | hit_intctl;
   wire [7:0]  status_view = {status_store[7:5], timeout_flag_in, powerdown_flag_in,
                              status_store[2:0]};

   wire        wr_pc_low   = wr & hit_pc_low;
   wire        wr_status   = wr & hit_status;
   wire        wr_pointer  = wr & hit_pointer;
   wire        wr_latch    = wr & hit_latch;
   wire        wr_intctl   = wr & hit_intctl;
   wire        wr_ram      = wr & ram_hit;
   wire [7:0]  ram_rdata;

   // Anything that is neither RAM nor a core register reads zero, so the peripheral slots
   // that this block does not model look unimplemented to software.
   assign region = ram_hit ? bmd_pkg::BMD_RG_RAM :
                   reg_hit ? bmd_pkg::BMD_RG_REG : bmd_pkg::BMD_RG_NONE;

   always_comb begin
      reg_rdata = 8'h00;
      if (hit_pc_low) begin
         reg_rdata = pc[7:0];
      end else if (hit_status) begin
         reg_rdata = status_view;
      end else if (hit_pointer) begin
         reg_rdata = pointer;
      end else if (hit_latch) begin
         reg_rdata = {3'h0, pc_latch};
      end else if (hit_intctl) begin
         reg_rdata = int_ctrl;
      end
   end

   // Interrupt entry beats a write to the counter low byte, which beats core branches.
   // A write to the low byte takes its upper bits from the latch in the same step, so
   // software must load the latch first to land on a far target.
   always_comb begin
      next_pc = pc;
      if (pc_cmd_in.irq_take) begin
         next_pc = `BMD_VEC_IRQ;
      end else if (wr_pc_low) begin
         next_pc = {pc_latch, data_cmd_in.wdata};
      end else if (pc_cmd_in.jump) begin
         next_pc = jump_addr;
      end else if (pc_cmd_in.ret) begin
         next_pc = pc_cmd_in.target;
      end else if (pc_cmd_in.advance) begin
         next_pc = 13'(pc + 13'h0001);
      end
   end

   // The counter restarts at the reset vector; store contents survive a reset.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc <= `BMD_VEC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // Arithmetic flags from the core win over a software write to the same bits.
   // Bits 4 and 3 are never stored: they are shown live from the flag inputs.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_store <= `BMD_STATUS_RESET;
      end else begin
         if (wr_status) begin
            status_store <= data_cmd_in.wdata & `BMD_ST_WR_MASK;
         end
         if (flag_we_in) begin
            status_store[2:0] <= flag_in;
         end
      end
   end

   // Pointer, counter latch and interrupt control answer at one offset in every bank.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pointer <= `BMD_POINTER_RESET;
      end else if (wr_pointer) begin
         pointer <= data_cmd_in.wdata;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_latch <= `BMD_LATCH_RESET;
      end else if (wr_latch) begin
         pc_latch <= data_cmd_in.wdata[4:0];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         int_ctrl <= `BMD_INTCTRL_RESET;
      end else if (wr_intctl) begin
         int_ctrl <= data_cmd_in.wdata;
      end
   end

   // Read answers one cycle after the request, matching the registered RAM output.
   // The answer stage keeps the decode of the request cycle, so a later change of the bank
   // bits or the pointer cannot alter a read already under way.
   logic [7:0] reg_rdata_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack         <= 1'b0;
         region_q    <= bmd_pkg::BMD_RG_NONE;
         reg_rdata_q <= 8'h00;
      end else begin
         ack         <= acc;
         region_q    <= region;
         reg_rdata_q <= reg_rdata;
      end
   end

   assign data_ack_out   = ack;
   assign data_rdata_out = (region_q == bmd_pkg::BMD_RG_RAM) ? ram_rdata :
                           (region_q == bmd_pkg::BMD_RG_REG) ? reg_rdata_q : 8'h00;
   assign pc_out         = pc;
   assign status_out     = status_view;
   assign int_ctrl_out   = int_ctrl;

   // Two separate memories let a fetch and a data access share a cycle.
   // The data RAM reads at the index it writes, so a read of a byte in the cycle after its
   // write already returns the new value.
   bmd_ram #(.ADDR_W(12), .DATA_W(14)) u_prog_store (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .wr_en_in    (prog_load_in.we),
      .wr_addr_in  (load_addr[11:0]),
      .wr_data_in  (prog_load_in.word),
      .rd_addr_in  (fetch_addr[11:0]),
      .rd_data_out (prog_word_out)
   );

   bmd_ram #(.ADDR_W(8), .DATA_W(8)) u_data_ram (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .wr_en_in    (wr_ram),
      .wr_addr_in  (ram_index),
      .wr_data_in  (data_cmd_in.wdata),
      .rd_addr_in  (ram_index),
      .rd_data_out (ram_rdata)
   );
endmodule

// file: verif/bmd_decode_sva.sv
// Port-level concurrent checks for the banked memory decoder.
`timescale 1ns/1ps
module bmd_decode_sva (
   input wire logic                   clk_in,
   input wire logic                   reset_n_in,
   input wire bmd_pkg::bmd_pc_cmd_t   pc_cmd_in,
   input wire logic [12:0]            pc_out,
   input wire logic                   data_req_in,
   input wire bmd_pkg::bmd_data_cmd_t data_cmd_in,
   input wire logic                   data_ack_out,
   input wire logic [7:0]             data_rdata_out,
   input wire logic [7:0]             status_out,
   input wire logic [7:0]             int_ctrl_out
);
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   wire logic [6:0] off     = data_cmd_in.offset;
   wire logic       wr_hit  = data_req_in && data_cmd_in.we;
   wire logic       pcl_wr  = wr_hit && off == 7'h02;
   wire logic       pc_busy = pc_cmd_in.irq_take || pc_cmd_in.jump || pc_cmd_in.ret || pcl_wr;
   ack_pulse_a: assert property (data_req_in |=> data_ack_out)
      else $error("data request without acknowledge");
   ack_cause_a: assert property (data_ack_out |-> $past(data_req_in))
      else $error("acknowledge without request");
   irq_vector_a: assert property (pc_cmd_in.irq_take |=> pc_out == 13'h0004)
      else $error("interrupt did not load vector four");
   reset_vector_a: assert property ($rose(reset_n_in) |-> pc_out == 13'h0000)
      else $error("program counter not zero after reset");
   advance_step_a: assert property (pc_cmd_in.advance && !pc_busy |=>
      pc_out == $past(pc_out) + 13'h0001) else $error("advance did not add one");
   bank_write_a: assert property (wr_hit && off == 7'h03 |=>
      status_out[6:5] == $past(data_cmd_in.wdata[6:5])) else $error("bank bits not written");
   bank_hold_a: assert property (!(wr_hit && off inside {7'h00, 7'h03}) |=>
      $stable(status_out[6:5])) else $error("bank bits changed unasked");
   pcl_write_a: assert property (pcl_wr && !pc_cmd_in.irq_take |=>
      pc_out[7:0] == $past(data_cmd_in.wdata)) else $error("low counter byte not loaded");
   intctrl_write_a: assert property (wr_hit && off == 7'h0b |=>
      int_ctrl_out == $past(data_cmd_in.wdata)) else $error("interrupt control not written");
   unimpl_zero_a: assert property (data_req_in && !data_cmd_in.we &&
      (off inside {7'h01, [7'h05:7'h09], [7'h0c:7'h1f]} ||
       (status_out[6:5] == 2'h3 && off inside {[7'h20:7'h6f]})) |=> data_rdata_out == 8'h00)
      else $error("unimplemented location read nonzero");
endmodule
bind bmd_decode bmd_decode_sva u_sva (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .pc_cmd_in(pc_cmd_in), .pc_out(pc_out),
   .data_req_in(data_req_in), .data_cmd_in(data_cmd_in), .data_ack_out(data_ack_out),
   .data_rdata_out(data_rdata_out), .status_out(status_out), .int_ctrl_out(int_ctrl_out));

// file: verif/bmd_core_model.sv
// Behavioural processor core that issues program and data requests to the decoder.
`timescale 1ns/1ps
module bmd_core_model (
   input  wire logic              clk_in,
   input  wire logic              data_ack_in,
   input  wire logic [7:0]        data_rdata_in,
   output bmd_pkg::bmd_pc_cmd_t   pc_cmd_out,
   output bmd_pkg::bmd_prog_load_t prog_load_out,
   output logic                   data_req_out,
   output bmd_pkg::bmd_data_cmd_t data_cmd_out
);
   initial begin
      pc_cmd_out = '0;
      prog_load_out = '0;
      data_req_out = 1'h0;
      data_cmd_out = '0;
   end
   task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d,
                      output logic [8:0] q);
      @(posedge clk_in);
      #1;
      data_req_out = 1'h1;
      data_cmd_out = {w, o, d};
      @(posedge clk_in);
      #1;
      data_req_out = 1'h0;
      // Idle command lines flip so a design that acts on stale values shows it.
      data_cmd_out = ~data_cmd_out;
      q = {data_ack_in, data_rdata_in};
   endtask
   task automatic load(input logic [12:0] a, input logic [13:0] w);
      @(posedge clk_in);
      #1;
      prog_load_out = {1'h1, a, w};
      @(posedge clk_in);
      #1;
      prog_load_out = '0;
   endtask
   task automatic pcop(input bmd_pkg::bmd_pc_cmd_t c);
      @(posedge clk_in);
      #1;
      pc_cmd_out = c;
      @(posedge clk_in);
      #1;
      pc_cmd_out = '0;
      @(posedge clk_in);
      #1;
   endtask
endmodule

// file: verif/test_banked_memory_map_decode.sv
// Self-checking testbench for the banked memory decoder.
`timescale 1ns/1ps
module test_banked_memory_map_decode;
   logic                   clk_in = 1'h0;
   logic                   reset_n_in = 1'h0;
   wire bmd_pkg::bmd_pc_cmd_t    pc_cmd;
   wire bmd_pkg::bmd_prog_load_t prog_load;
   wire bmd_pkg::bmd_data_cmd_t  data_cmd;
   wire logic [12:0]       pc;
   wire logic [13:0]       word;
   wire logic [7:0]        rdata, status, int_ctrl;
   wire logic              data_req, ack;
   logic [8:0]             q;
   int                     n_mismatch = 0;
   int                     total_checks = 0;
   always #5 clk_in = ~clk_in;
   bmd_decode dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .pc_cmd_in(pc_cmd),
      .prog_load_in(prog_load), .pc_out(pc), .prog_word_out(word),
      .data_req_in(data_req), .data_cmd_in(data_cmd), .data_ack_out(ack),
      .data_rdata_out(rdata), .flag_we_in(1'h0), .flag_in(3'h0), .timeout_flag_in(1'h1),
      .powerdown_flag_in(1'h0), .status_out(status), .int_ctrl_out(int_ctrl));
   bmd_core_model core (
      .clk_in(clk_in), .data_ack_in(ack), .data_rdata_in(rdata), .pc_cmd_out(pc_cmd),
      .prog_load_out(prog_load), .data_req_out(data_req), .data_cmd_out(data_cmd));
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic rd(input logic [6:0] o, input logic [7:0] e);
      core.acc(1'h0, o, 8'h00, q);
      chk("read", {1'h1, e}, q);
   endtask
   task automatic wr(input logic [6:0] o, input logic [7:0] d);
      core.acc(1'h1, o, d, q);
      chk("write ack", 9'h100, {q[8], 8'h00});
   endtask
   task automatic bank(input logic [1:0] b);
      wr(7'h03, {1'h0, b, 5'h00});
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge clk_in);
      #1;
      reset_n_in = 1'h1;
      chk("pc", 13'h0000, pc);
      chk("status", 8'h10, status);
      core.load(13'h0004, 14'h2abc);
      core.load(13'h0005, 14'h1234);
      core.pcop({4'h8, 13'h0000});
      chk("pc", 13'h0004, pc);
      chk("word", 14'h2abc, word);
      core.pcop({4'h2, 13'h1805});
      chk("pc", 13'h1805, pc);
      chk("word", 14'h1234, word);
      core.pcop({4'h1, 13'h0000});
      chk("pc", 13'h1806, pc);
      $display("test program_map done");
      for (int b = 0; b < 4; b++) begin
         bank(b[1:0]);
         chk("status", {1'h0, b[1:0], 5'h10}, status);
         wr(7'h30, 8'h10 + b[7:0]);
      end
      for (int b = 0; b < 4; b++) begin
         bank(b[1:0]);
         rd(7'h30, (b == 3) ? 8'h00 : 8'h10 + b[7:0]);
      end
      bank(2'h2);
      wr(7'h7f, 8'h5a);
      bank(2'h0);
      rd(7'h7f, 8'h5a);
      wr(7'h20, 8'h77);
      rd(7'h20, 8'h77);
      rd(7'h1f, 8'h00);
      rd(7'h01, 8'h00);
      bank(2'h3);
      rd(7'h7f, 8'h5a);
      $display("test banks done");
      wr(7'h04, 8'ha5);
      wr(7'h00, 8'h3c);
      bank(2'h1);
      rd(7'h25, 8'h3c);
      rd(7'h00, 8'h3c);
      rd(7'h04, 8'ha5);
      wr(7'h04, 8'h00);
      rd(7'h00, 8'h00);
      bank(2'h2);
      wr(7'h0b, 8'h81);
      chk("int_ctrl", 8'h81, int_ctrl);
      bank(2'h0);
      rd(7'h0b, 8'h81);
      wr(7'h0a, 8'h01);
      wr(7'h02, 8'h23);
      chk("pc", 13'h0123, pc);
      rd(7'h02, 8'h23);
      wr(7'h0a, 8'h18);
      core.pcop({4'h4, 13'h0123});
      chk("pc", 13'h1923, pc);
      $display("test indirect_mirror done");
      reset_n_in = 1'h0;
      repeat (2) @(posedge clk_in);
      #1;
      reset_n_in = 1'h1;
      chk("pc", 13'h0000, pc);
      chk("status", 8'h10, status);
      chk("int_ctrl", 8'h00, int_ctrl);
      rd(7'h04, 8'h00);
      $display("test reset done");
      print_verdict();
   end
endmodule
